// ### core/flash_ctl_map.svh
// Opcode values, field limits and timing counts of the suspend, resume and reset controller.
// Assumes the includer compiles it once per unit; the guard keeps repeats harmless.
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH

// Opcodes.
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_CONFIG_READ 8'h15
`define OPC_SEC_READ 8'h2b
`define OPC_SEC_WRITE 8'h2f
`define OPC_SIGNATURE_READ 8'hab
`define OPC_RESET_ARM 8'h66
`define OPC_SOFT_RESET 8'h99
`define OPC_NO_OP 8'h00
`define OPC_READ 8'h03
`define OPC_FAST_READ 8'h0b
`define OPC_DUAL_OUT_READ 8'h3b
`define OPC_QUAD_OUT_READ 8'h6b
`define OPC_DUAL_IO_READ 8'hbb
`define OPC_QUAD_IO_READ 8'heb
`define OPC_PARAM_READ 8'h5a
`define OPC_IDENT_READ 8'h9f
`define OPC_MAKER_ID_READ 8'h90
`define OPC_BURST_SET 8'hc0
`define OPC_OTP_ENTER 8'hb1
`define OPC_OTP_EXIT 8'hc1
`define OPC_RESUME_A 8'h7a
`define OPC_RESUME_B 8'h30
`define OPC_SUSPEND_A 8'h75
`define OPC_SUSPEND_B 8'hb0
`define OPC_PAGE_PROG 8'h02
`define OPC_QUAD_PAGE_PROG 8'h38
`define OPC_SECTOR_ERASE 8'h20
`define OPC_BLOCK32_ERASE 8'h52
`define OPC_BLOCK64_ERASE 8'hd8

// Region sizes as low address masks, and the end of the lockable OTP part.
`define MASK_PAGE 24'h00_00ff
`define MASK_SECTOR 24'h00_0fff
`define MASK_BLOCK32 24'h00_7fff
`define MASK_BLOCK64 24'h00_ffff
`define OTP_LOCK_LIMIT 24'h00_0200

// Frame lengths in bits.
`define BITS_OPCODE 6'h08
`define BITS_WITH_ADDR 6'h20

// Timing in nanoseconds, and the clock period used to turn them into cycles.
`define CLK_PERIOD_NS 50
`define PROG_SUSPEND_LAT_NS 10000
`define ERASE_SUSPEND_LAT_NS 15000
`define RECOVERY_PROG_NS 40000
`define RECOVERY_OTHER_NS 20000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### core/flash_ctl_pkg.sv
// Types shared by the suspend, resume and reset controller and its helpers.
// Assumes the map header supplies every number; this package holds only types.
package flash_ctl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BUSY = 3'h1,
    ST_SUSP_WAIT = 3'h2,
    ST_SUSPENDED = 3'h3,
    ST_RECOVER = 3'h4
  } state_t;

  typedef enum logic {
    KIND_PROG = 1'b0,
    KIND_ERASE = 1'b1
  } op_kind_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [5:0] nbits;
  } frame_t;

  typedef struct packed {
    state_t st;
    logic [11:0] cnt;
    logic write_enable_latch;
    logic write_in_progress;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic lock;
    logic arm;
    logic otp;
    logic nest;
    logic rdy;
    logic cs_n_d;
    logic sclk_d;
    op_kind_t kind;
    logic [23:0] base;
    logic [23:0] low;
    logic ok;
    logic refused;
    logic op_start;
    op_kind_t start_kind;
    logic op_suspend;
    logic op_resume;
    logic op_abort;
    logic lock_prog;
    logic [7:0] op;
    logic [23:0] addr;
  } ctl_state_t;

endpackage

// ### core/pin_sync.sv
// Two-stage synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [1:0][W-1:0] s_q;
  logic [1:0][W-1:0] s_d;

  always_comb begin
    s_d = {s_q[0], d};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q[1];
endmodule // pin_sync

// ### core/cmd_shifter.sv
// Collects the opcode and the three address bytes of a serial frame, counting bits.
// Assumes shift pulses come from the clock-domain edge finder while chip select is low.
`timescale 1ns/100ps
`include "flash_ctl_map.svh"
module cmd_shifter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic shift,
  input wire logic bit_in,
  output flash_ctl_pkg::frame_t frame
);
  flash_ctl_pkg::frame_t f_q;
  flash_ctl_pkg::frame_t f_d;

  always_comb begin
    f_d = f_q;
    if (clear) begin
      f_d = '0;
    end else if (shift) begin
      if (f_q.nbits < `BITS_OPCODE) begin
        f_d.opcode = {f_q.opcode[6:0], bit_in};
      end else if (f_q.nbits < `BITS_WITH_ADDR) begin
        f_d.addr = {f_q.addr[22:0], bit_in};
      end
      // The count saturates so that long data phases never wrap into a byte boundary.
      if (f_q.nbits != 6'h3f) begin
        f_d.nbits = f_q.nbits + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign frame = f_q;
endmodule // cmd_shifter

// ### core/flash_suspend_resume_reset_ctl.sv
// Command gate of a serial NOR flash: security write, suspend, resume and soft reset.
// Assumes the array engine runs operations on OP_START and reports OP_DONE on MCLK.
`timescale 1ns/100ps
`include "flash_ctl_map.svh"

module flash_suspend_resume_reset_ctl (
  // Clock and reset.
  input wire logic MCLK,
  input wire logic RST_N,
  // Serial pins.
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SI,
  // Array engine, read mode and non-volatile lock copy.
  input wire logic OP_DONE,
  input wire logic PERF_MODE,
  input wire logic LOCK_NV,
  // Status.
  output logic WRITE_ENABLE_LATCH,
  output logic WRITE_IN_PROGRESS,
  output logic PSB_FLAG,
  output logic ESB_FLAG,
  output logic LOCKDOWN,
  output logic OTP_MODE,
  output logic READY,
  // Command verdicts.
  output logic CMD_OK,
  output logic CMD_REFUSED,
  output logic [7:0] CMD_OP,
  output logic [23:0] CMD_ADDR,
  // Array engine control.
  output logic OP_START,
  output logic OP_KIND,
  output logic OP_SUSPEND,
  output logic OP_RESUME,
  output logic OP_ABORT,
  output logic LOCK_PROGRAM
);
  localparam logic [11:0] PSUS_CYC = 12'(`NS_TO_CYC(`PROG_SUSPEND_LAT_NS));
  localparam logic [11:0] ESUS_CYC = 12'(`NS_TO_CYC(`ERASE_SUSPEND_LAT_NS));
  localparam logic [11:0] RPROG_CYC = 12'(`NS_TO_CYC(`RECOVERY_PROG_NS));
  localparam logic [11:0] ROTHER_CYC = 12'(`NS_TO_CYC(`RECOVERY_OTHER_NS));

  flash_ctl_pkg::ctl_state_t q;
  flash_ctl_pkg::ctl_state_t d;
  flash_ctl_pkg::frame_t fr;
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic frame_end;

  pin_sync #(.W(3)) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({CS_N, SCLK, SI}),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign si_s = pins_s[0];
  assign frame_end = cs_n_s && !q.cs_n_d;

  // Bits are sampled on the synchronised rising edge of the link clock.
  cmd_shifter u_shift (
    .clk(MCLK),
    .rst_n(RST_N),
    .clear(cs_n_s && q.cs_n_d),
    .shift(!cs_n_s && sclk_s && !q.sclk_d),
    .bit_in(si_s),
    .frame(fr)
  );

  always_comb begin
    logic rej;
    logic whole;
    logic susp;
    logic any_time;
    logic lat_set;
    logic es_set;
    logic in_reg;
    logic has_addr;
    rej = 1'b0;
    whole = (fr.nbits != 6'h00) && (fr.nbits[2:0] == 3'h0);
    susp = (q.st == flash_ctl_pkg::ST_SUSP_WAIT) || (q.st == flash_ctl_pkg::ST_SUSPENDED);
    has_addr = fr.nbits >= `BITS_WITH_ADDR;
    in_reg = ((fr.addr ^ q.base) & ~q.low) == 24'h00_0000;
    any_time = 1'b0;
    lat_set = 1'b0;
    es_set = 1'b0;
    case (fr.opcode)
      `OPC_WRITE_DISABLE, `OPC_STATUS_READ, `OPC_CONFIG_READ, `OPC_SEC_READ,
      `OPC_SIGNATURE_READ, `OPC_RESET_ARM, `OPC_SOFT_RESET, `OPC_NO_OP: begin
        any_time = 1'b1;
      end
      `OPC_READ, `OPC_FAST_READ, `OPC_DUAL_OUT_READ, `OPC_QUAD_OUT_READ, `OPC_DUAL_IO_READ,
      `OPC_QUAD_IO_READ, `OPC_PARAM_READ, `OPC_IDENT_READ, `OPC_MAKER_ID_READ,
      `OPC_BURST_SET, `OPC_OTP_ENTER, `OPC_OTP_EXIT, `OPC_RESUME_A, `OPC_RESUME_B: begin
        lat_set = 1'b1;
      end
      `OPC_WRITE_ENABLE, `OPC_PAGE_PROG, `OPC_QUAD_PAGE_PROG: begin
        es_set = 1'b1;
      end
      default: begin
        any_time = 1'b0;
      end
    endcase

    d = q;
    d.cs_n_d = cs_n_s;
    d.sclk_d = sclk_s;
    d.ok = 1'b0;
    d.refused = 1'b0;
    d.op_start = 1'b0;
    d.op_suspend = 1'b0;
    d.op_resume = 1'b0;
    d.op_abort = 1'b0;
    d.lock_prog = 1'b0;

    case (q.st)
      flash_ctl_pkg::ST_BUSY: begin
        if (OP_DONE) begin
          d.st = flash_ctl_pkg::ST_IDLE;
          d.write_in_progress = 1'b0;
          d.write_enable_latch = 1'b0;
        end
      end
      flash_ctl_pkg::ST_SUSP_WAIT: begin
        if (q.cnt <= 12'h001) begin
          d.st = flash_ctl_pkg::ST_SUSPENDED;
          d.write_enable_latch = 1'b0;
          d.write_in_progress = 1'b0;
          d.program_suspended_flag = (q.kind == flash_ctl_pkg::KIND_PROG);
          d.erase_suspended_flag = (q.kind == flash_ctl_pkg::KIND_ERASE);
        end else begin
          d.cnt = q.cnt - 12'h001;
        end
      end
      flash_ctl_pkg::ST_SUSPENDED: begin
        // The nested program leaves both bits high until the engine reports it finished.
        if (q.nest && OP_DONE) begin
          d.nest = 1'b0;
          d.write_in_progress = 1'b0;
          d.write_enable_latch = 1'b0;
        end
      end
      flash_ctl_pkg::ST_RECOVER: begin
        if (q.cnt <= 12'h001) begin
          d.st = flash_ctl_pkg::ST_IDLE;
        end else begin
          d.cnt = q.cnt - 12'h001;
        end
      end
      default: begin
        d.st = q.st;
      end
    endcase

    // Commands are judged when chip select rises; recovery ignores every frame.
    if (frame_end && (fr.nbits != 6'h00) && (q.st != flash_ctl_pkg::ST_RECOVER)) begin
      rej = !whole;
      if (susp && !(any_time || ((q.st == flash_ctl_pkg::ST_SUSPENDED) &&
                                 (lat_set || (q.erase_suspended_flag && es_set))))) begin
        rej = 1'b1;
      end
      d.arm = 1'b0;
      if (!rej) begin
        case (fr.opcode)
          `OPC_WRITE_ENABLE: begin
            d.write_enable_latch = 1'b1;
          end
          `OPC_WRITE_DISABLE: begin
            d.write_enable_latch = q.write_in_progress;
          end
          `OPC_RESET_ARM: begin
            d.arm = 1'b1;
          end
          `OPC_SEC_WRITE: begin
            if ((fr.nbits == `BITS_OPCODE) && q.write_enable_latch && !q.write_in_progress && !q.otp) begin
              d.lock = 1'b1;
              d.lock_prog = !q.lock;
              d.write_enable_latch = 1'b0;
            end else begin
              rej = 1'b1;
            end
          end
          `OPC_SOFT_RESET: begin
            if (q.arm) begin
              d.op_abort = q.write_in_progress || q.program_suspended_flag || q.erase_suspended_flag;
              d.cnt = (q.nest || ((q.write_in_progress || q.program_suspended_flag) && (q.kind == flash_ctl_pkg::KIND_PROG)))
                      ? RPROG_CYC : ROTHER_CYC;
              d.st = flash_ctl_pkg::ST_RECOVER;
              d.write_enable_latch = 1'b0;
              d.write_in_progress = 1'b0;
              d.program_suspended_flag = 1'b0;
              d.erase_suspended_flag = 1'b0;
              d.otp = 1'b0;
              d.nest = 1'b0;
            end else begin
              rej = 1'b1;
            end
          end
          `OPC_SUSPEND_A, `OPC_SUSPEND_B: begin
            if ((q.st == flash_ctl_pkg::ST_BUSY) && !q.nest) begin
              d.st = flash_ctl_pkg::ST_SUSP_WAIT;
              d.cnt = (q.kind == flash_ctl_pkg::KIND_PROG) ? PSUS_CYC : ESUS_CYC;
              d.op_suspend = 1'b1;
            end else begin
              rej = 1'b1;
            end
          end
          `OPC_RESUME_A, `OPC_RESUME_B: begin
            if (!PERF_MODE && (q.program_suspended_flag || q.erase_suspended_flag) && !q.nest) begin
              d.program_suspended_flag = 1'b0;
              d.erase_suspended_flag = 1'b0;
              d.write_enable_latch = 1'b1;
              d.write_in_progress = 1'b1;
              d.st = flash_ctl_pkg::ST_BUSY;
              d.op_resume = 1'b1;
            end else begin
              rej = 1'b1;
            end
          end
          `OPC_PAGE_PROG, `OPC_QUAD_PAGE_PROG: begin
            if (!has_addr || !q.write_enable_latch || q.write_in_progress) begin
              rej = 1'b1;
            end else if (q.otp && q.lock && (fr.addr < `OTP_LOCK_LIMIT)) begin
              rej = 1'b1;
            end else if (susp) begin
              if (in_reg) begin
                rej = 1'b1;
              end else begin
                d.nest = 1'b1;
                d.write_in_progress = 1'b1;
                d.op_start = 1'b1;
                d.start_kind = flash_ctl_pkg::KIND_PROG;
              end
            end else begin
              d.st = flash_ctl_pkg::ST_BUSY;
              d.write_in_progress = 1'b1;
              d.kind = flash_ctl_pkg::KIND_PROG;
              d.base = fr.addr;
              d.low = `MASK_PAGE;
              d.op_start = 1'b1;
              d.start_kind = flash_ctl_pkg::KIND_PROG;
            end
          end
          `OPC_SECTOR_ERASE, `OPC_BLOCK32_ERASE, `OPC_BLOCK64_ERASE: begin
            if (has_addr && q.write_enable_latch && !q.write_in_progress && !susp && !q.otp) begin
              d.st = flash_ctl_pkg::ST_BUSY;
              d.write_in_progress = 1'b1;
              d.kind = flash_ctl_pkg::KIND_ERASE;
              d.base = fr.addr;
              d.low = (fr.opcode == `OPC_SECTOR_ERASE) ? `MASK_SECTOR :
                      (fr.opcode == `OPC_BLOCK32_ERASE) ? `MASK_BLOCK32 : `MASK_BLOCK64;
              d.op_start = 1'b1;
              d.start_kind = flash_ctl_pkg::KIND_ERASE;
            end else begin
              rej = 1'b1;
            end
          end
          `OPC_OTP_ENTER: begin
            d.otp = 1'b1;
          end
          `OPC_OTP_EXIT: begin
            d.otp = 1'b0;
          end
          `OPC_READ, `OPC_FAST_READ, `OPC_DUAL_OUT_READ, `OPC_QUAD_OUT_READ,
          `OPC_DUAL_IO_READ, `OPC_QUAD_IO_READ: begin
            // Reads inside the paused region would see half-written cells.
            if (susp && !q.otp && in_reg) begin
              rej = 1'b1;
            end
          end
          default: begin
            rej = 1'b0;
          end
        endcase
      end
      d.ok = !rej;
      d.refused = rej;
      d.op = fr.opcode;
      d.addr = fr.addr;
    end
    d.rdy = (d.st != flash_ctl_pkg::ST_RECOVER);
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      q <= '0;
      q.cs_n_d <= 1'b1;
      q.sclk_d <= 1'b1;
      q.st <= flash_ctl_pkg::ST_IDLE;
      q.rdy <= 1'b1;
    end else begin
      q <= d;
      // The stored lock bit reloads from the non-volatile copy, so it can only rise.
      q.lock <= d.lock | LOCK_NV;
    end
  end

  assign WRITE_ENABLE_LATCH = q.write_enable_latch;
  assign WRITE_IN_PROGRESS = q.write_in_progress;
  assign PSB_FLAG = q.program_suspended_flag;
  assign ESB_FLAG = q.erase_suspended_flag;
  assign LOCKDOWN = q.lock;
  assign OTP_MODE = q.otp;
  assign READY = q.rdy;
  assign CMD_OK = q.ok;
  assign CMD_REFUSED = q.refused;
  assign CMD_OP = q.op;
  assign CMD_ADDR = q.addr;
  assign OP_START = q.op_start;
  assign OP_KIND = q.start_kind;
  assign OP_SUSPEND = q.op_suspend;
  assign OP_RESUME = q.op_resume;
  assign OP_ABORT = q.op_abort;
  assign LOCK_PROGRAM = q.lock_prog;

  localparam int LAT_HI = 302;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence s_suspend_taken;
    q.op_suspend;
  endsequence

  sequence s_suspend_done;
    (q.program_suspended_flag || q.erase_suspended_flag) && !q.write_enable_latch;
  endsequence

  a_susp_latency: assert property (s_suspend_taken |-> ##[1:LAT_HI] s_suspend_done)
    else $error("Suspend did not settle within its latency.");
  a_susp_early: assert property (s_suspend_taken |=> (!q.program_suspended_flag && !q.erase_suspended_flag) [*8])
    else $error("Suspended flag set before the latency elapsed.");
  a_lock_needs_wel: assert property ($rose(q.lock_prog) |-> $past(q.write_enable_latch))
    else $error("Lockdown written without write enable.");
  a_lock_sticky: assert property (q.lock |=> q.lock)
    else $error("Lockdown flag cleared.");
  a_otp_guard: assert property (q.op_start && q.otp && q.lock |-> q.addr >= `OTP_LOCK_LIMIT)
    else $error("Locked OTP area was programmed.");
  a_flag_excl: assert property (q.st == flash_ctl_pkg::ST_SUSPENDED |-> q.program_suspended_flag != q.erase_suspended_flag)
    else $error("Suspended flags disagree with state.");
  a_resume_bits: assert property (q.op_resume |-> q.write_enable_latch && q.write_in_progress && !q.program_suspended_flag && !q.erase_suspended_flag)
    else $error("Resume left wrong status bits.");
  a_nest_busy: assert property (q.nest |-> q.write_enable_latch && q.write_in_progress && q.erase_suspended_flag)
    else $error("Nested program lost its busy bits.");
  a_no_nest_susp: assert property (q.nest |-> !q.op_suspend && !q.op_resume)
    else $error("Nested program was suspended or resumed.");
  a_reset_clear: assert property ($rose(q.st == flash_ctl_pkg::ST_RECOVER) |->
                                  !q.write_enable_latch && !q.write_in_progress && !q.program_suspended_flag && !q.erase_suspended_flag && !q.arm)
    else $error("Soft reset left volatile bits set.");
  a_arm_cancel: assert property (q.ok && q.op != `OPC_RESET_ARM |-> !q.arm)
    else $error("Reset arm survived another command.");
  a_perf_resume: assert property (q.op_resume |-> !$past(PERF_MODE))
    else $error("Resume acted in enhanced read mode.");
endmodule // flash_suspend_resume_reset_ctl

// ### tb/spi_host_model.sv
// Behavioural host that frames commands on the serial pins of the flash controller.
// Assumes one caller at a time; the link clock has a 400 ns period and rests low between frames.
`timescale 1ns/100ps
module spi_host_model (
  // Serial pins.
  output logic cs_n,
  output logic sclk,
  output logic si
);
  initial begin
    cs_n = 1'h1;
    sclk = 1'h0;
    si = 1'h0;
  end

  // Sends n bits of the opcode and address, MSB first; the caller picks torn lengths on purpose.
  task automatic send(input logic [7:0] op, input logic [23:0] addr, input int n);
    logic [31:0] word;
    int i;
    word = {op, addr};
    #400 cs_n = 1'h0;
    for (i = 0; i < n; i++) begin
      si = word[31 - (i % 32)];
      #200 sclk = 1'h1;
      #200 sclk = 1'h0;
    end
    #200 cs_n = 1'h1;
    // A released line shows the inverse, so a stale bit is never taken for data.
    si = ~si;
  endtask
endmodule // spi_host_model

// ### tb/tb_flash_suspend_resume_reset_ctl.sv
// Self-checking bench of the suspend, resume and reset controller.
// Assumes the host model drives the serial pins and the bench plays the array engine.
`timescale 1ns/100ps
module tb_flash_suspend_resume_reset_ctl;
  logic MCLK = 1'h0;
  logic RST_N = 1'h0;
  logic OP_DONE = 1'h0;
  logic PERF_MODE = 1'h0;
  logic LOCK_NV = 1'h0;
  logic CS_N, SCLK, SI, OP_ABORT, OP_START, OP_KIND, OP_SUSPEND, OP_RESUME, LOCK_PROGRAM;
  logic WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, PSB_FLAG, ESB_FLAG, LOCKDOWN, OTP_MODE, READY, CMD_OK, CMD_REFUSED;
  logic [7:0] CMD_OP;
  logic [23:0] CMD_ADDR;
  logic abort_seen = 1'h0;
  logic [3:0] pulse_seen = 4'h0;
  int failures = 0;
  int samples_checked = 0;
  logic [7:0] late_ops [12] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb, 8'h5a, 8'h9f,
                                8'h90, 8'hc0, 8'hb1, 8'hc1};
  logic [7:0] any_ops [7] = '{8'h04, 8'h05, 8'h15, 8'h2b, 8'hab, 8'h66, 8'h00};

  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    if (OP_ABORT === 1'h1) begin
      abort_seen <= 1'h1;
    end
    pulse_seen <= pulse_seen | {OP_START === 1'h1, OP_SUSPEND === 1'h1, OP_RESUME === 1'h1,
                                LOCK_PROGRAM === 1'h1};
  end

  spi_host_model host_u (.cs_n(CS_N), .sclk(SCLK), .si(SI));
  flash_suspend_resume_reset_ctl dut_u (.MCLK(MCLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK),
    .SI(SI), .OP_DONE(OP_DONE), .PERF_MODE(PERF_MODE), .LOCK_NV(LOCK_NV), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH), .WRITE_IN_PROGRESS(WRITE_IN_PROGRESS),
    .PSB_FLAG(PSB_FLAG), .ESB_FLAG(ESB_FLAG), .LOCKDOWN(LOCKDOWN), .OTP_MODE(OTP_MODE),
    .READY(READY), .CMD_OK(CMD_OK), .CMD_REFUSED(CMD_REFUSED), .CMD_OP(CMD_OP),
    .CMD_ADDR(CMD_ADDR), .OP_START(OP_START), .OP_KIND(OP_KIND), .OP_SUSPEND(OP_SUSPEND),
    .OP_RESUME(OP_RESUME), .OP_ABORT(OP_ABORT), .LOCK_PROGRAM(LOCK_PROGRAM));

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  // Sends one frame and judges the verdict pulse, which stands for a single cycle.
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input logic ok);
    int i;
    host_u.send(op, a, n);
    for (i = 0; i < 20; i++) begin
      cyc(1);
      if (CMD_OK === 1'h1 || CMD_REFUSED === 1'h1) break;
    end
    if (i == 20) begin
      failures++;
      finish_test();
    end
    check({CMD_OK, CMD_REFUSED, CMD_OP}, {ok, !ok, op});
    check(CMD_ADDR, a);
  endtask

  task automatic cmd(input logic [7:0] op, input logic ok);
    frame(op, 24'h00_0000, 8, ok);
  endtask

  task automatic wait_flag(input logic erase_suspended_flag);
    int i;
    for (i = 0; i < 400 && (PSB_FLAG | ESB_FLAG) !== 1'h1; i++) cyc(1);
    if (i == 400) begin
      failures++;
      finish_test();
    end
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, PSB_FLAG, ESB_FLAG}, {2'h0, !erase_suspended_flag, erase_suspended_flag});
  endtask

  task automatic done_pulse();
    OP_DONE = 1'h1;
    cyc(1);
    OP_DONE = 1'h0;
    cyc(2);
  endtask

  task automatic recover(input int lo, input int hi);
    int n;
    for (n = 0; n < 2000 && READY !== 1'h1; n++) cyc(1);
    if (n == 2000) begin
      failures++;
      finish_test();
    end
    check(n >= lo && n <= hi, 1'h1);
  endtask

  task automatic t_security();
    cmd(8'h2f, 1'h0);
    cmd(8'h06, 1'h1);
    frame(8'h2f, 24'h00_0000, 12, 1'h0);
    frame(8'h2f, 24'h00_0000, 16, 1'h0);
    cmd(8'h2f, 1'h1);
    check(LOCKDOWN, 1'h1);
    cmd(8'hb1, 1'h1);
    cmd(8'h06, 1'h1);
    frame(8'h02, 24'h00_0100, 32, 1'h0);
    frame(8'h02, 24'h00_0300, 32, 1'h1);
    done_pulse();
    cmd(8'hc1, 1'h1);
    cmd(8'h04, 1'h1);
    check({WRITE_ENABLE_LATCH, OTP_MODE}, 2'h0);
    check(pulse_seen, 4'h9);
    $display("Test security done");
  endtask

  task automatic t_prog_suspend();
    cmd(8'h75, 1'h0);
    check({PSB_FLAG, ESB_FLAG}, 2'h0);
    check(pulse_seen, 4'h9);
    cmd(8'h06, 1'h1);
    frame(8'h02, 24'h00_1234, 32, 1'h1);
    cmd(8'h75, 1'h1);
    cmd(8'h03, 1'h0);
    foreach (any_ops[i]) cmd(any_ops[i], 1'h1);
    wait_flag(1'h0);
    check(pulse_seen, 4'hd);
    cmd(8'h06, 1'h0);
    frame(8'h38, 24'h00_4000, 32, 1'h0);
    frame(8'h03, 24'h00_1200, 32, 1'h0);
    frame(8'h03, 24'h00_1300, 32, 1'h1);
    foreach (late_ops[i]) frame(late_ops[i], 24'h00_4000, 32, 1'h1);
    frame(8'h20, 24'h00_8000, 32, 1'h0);
    PERF_MODE = 1'h1;
    cmd(8'h7a, 1'h0);
    PERF_MODE = 1'h0;
    cmd(8'h7a, 1'h1);
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, PSB_FLAG}, 3'h6);
    done_pulse();
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS}, 2'h0);
    check(pulse_seen, 4'hf);
    $display("Test program suspend done");
  endtask

  task automatic t_erase_suspend();
    cmd(8'h06, 1'h1);
    frame(8'h20, 24'h01_0000, 32, 1'h1);
    check(OP_KIND, 1'h1);
    cmd(8'hb0, 1'h1);
    wait_flag(1'h1);
    cmd(8'h06, 1'h1);
    frame(8'h38, 24'h01_0100, 32, 1'h0);
    frame(8'h02, 24'h02_0000, 32, 1'h1);
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, ESB_FLAG, OP_KIND}, 4'he);
    cmd(8'h75, 1'h0);
    cmd(8'h30, 1'h0);
    done_pulse();
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, ESB_FLAG}, 3'h1);
    cmd(8'h30, 1'h1);
    check({WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, ESB_FLAG}, 3'h6);
    done_pulse();
    $display("Test erase suspend done");
  endtask

  task automatic t_reset();
    cmd(8'h66, 1'h1);
    cmd(8'h00, 1'h1);
    cmd(8'h99, 1'h0);
    cmd(8'h06, 1'h1);
    cmd(8'h66, 1'h1);
    cmd(8'h05, 1'h1);
    cmd(8'h99, 1'h0);
    cmd(8'h66, 1'h1);
    cmd(8'h99, 1'h1);
    check({WRITE_ENABLE_LATCH, READY}, 2'h0);
    recover(300, 500);
    check(abort_seen, 1'h0);
    cmd(8'h06, 1'h1);
    frame(8'h02, 24'h00_3000, 32, 1'h1);
    cmd(8'h66, 1'h1);
    cmd(8'h99, 1'h1);
    cyc(1);
    check({abort_seen, WRITE_ENABLE_LATCH, WRITE_IN_PROGRESS, READY}, 4'h8);
    recover(700, 900);
    $display("Test soft reset done");
  endtask

  initial begin
    repeat (10) @(posedge MCLK);
    #1 RST_N = 1'h1;
    cyc(4);
    t_security();
    t_prog_suspend();
    t_erase_suspend();
    t_reset();
    finish_test();
  end
endmodule // tb_flash_suspend_resume_reset_ctl
